// File: verification/adcc_analog_model.sv
`timescale 1ns/1ns
`default_nettype none
module adcc_analog_model (
   // Clock
   input wire logic clk,
   // Converter side
   input wire adcc_pkg::adcc_analog_s analogCtrl,
   input wire logic [11:0] extLevel,
   input wire logic [11:0] ampLevel,
   // Comparator
   output logic cmpAbove
);
   logic [11:0] level;
   logic toggle = 1'b0;
   always_ff @(posedge clk) toggle <= !toggle;
   always_comb begin
      case (analogCtrl.route.intSrc)
         adcc_pkg::ADCC_INT_SUPPLY: level = 12'hfff;
         adcc_pkg::ADCC_INT_SUPPLY_DIV2: level = 12'h7ff;
         adcc_pkg::ADCC_INT_SUPPLY_DIV4: level = 12'h3ff;
         adcc_pkg::ADCC_INT_AMP: level = ampLevel;
         adcc_pkg::ADCC_INT_AMP_DIV2: level = ampLevel >> 1;
         adcc_pkg::ADCC_INT_AMP_DIV4: level = ampLevel >> 2;
         default: level = 12'h000;
      endcase
      if (analogCtrl.route.extConnect) begin
         level = extLevel ^ {8'h00, analogCtrl.route.extChan};
      end
   end
   // Outside conversion the comparator output is meaningless, so it wanders
   assign cmpAbove = analogCtrl.converting ? (level >= analogCtrl.trialCode) : toggle;
endmodule : adcc_analog_model
`default_nettype wire

// File: verification/adcc_conversion_control_monitor.sv
`timescale 1ns/1ns
`default_nettype none
module adcc_conversion_control_monitor (
   // Clock and reset
   input wire logic clk,
   input wire logic reset,
   // Bus
   input wire logic read,
   input wire logic write,
   input wire logic [31:0] readdata,
   input wire logic waitrequest,
   // Analog and interrupt
   input wire adcc_pkg::adcc_analog_s analogCtrl,
   input wire logic irq
);
   default clocking cb @(posedge clk); endclocking
   default disable iff (reset);
   wire logic req = read || write;
   wire logic busyPhase = analogCtrl.sampling || analogCtrl.converting;
   wire logic wrDone = write && !waitrequest;
   a_wait_first: assert property ($rose(req) |-> waitrequest) else $error("no wait state");
   a_one_wait: assert property ($rose(req) |=> !waitrequest) else $error("answer late");
   a_read_upper: assert property (readdata[31:8] == 24'h000000) else $error("upper read bits set");
   a_phase_exclusive: assert property (!(analogCtrl.sampling && analogCtrl.converting))
      else $error("sampling and converting together");
   a_sample_then_convert: assert property ($fell(analogCtrl.sampling) && analogCtrl.powerOn |->
      analogCtrl.converting) else $error("sampling not followed by converting");
   a_first_trial: assert property ($rose(analogCtrl.converting) |->
      analogCtrl.trialCode == 12'h800) else $error("first trial not top bit");
   a_route_exclusive: assert property (analogCtrl.route.extConnect |->
      analogCtrl.route.intSrc == adcc_pkg::ADCC_INT_NONE) else $error("channel and internal together");
   a_ref_legal: assert property (analogCtrl.refSel != 2'h3) else $error("bad reference code");
   a_power_gates: assert property (busyPhase && !analogCtrl.powerOn |=> !busyPhase)
      else $error("converting unpowered");
   a_irq_rise_cause: assert property ($rose(irq) |-> $past(busyPhase) || $past(wrDone, 2))
      else $error("interrupt rose without cause");
   a_irq_fall_cause: assert property ($fell(irq) |-> $past(wrDone, 2))
      else $error("interrupt fell without write");
endmodule : adcc_conversion_control_monitor
bind adcc_conversion_control adcc_conversion_control_monitor u_mon (.clk(clk), .reset(reset), .read(read),
   .write(write), .readdata(readdata), .waitrequest(waitrequest), .analogCtrl(analogCtrl), .irq(irq));
`default_nettype wire

// File: verification/test_adcc_conversion_control.sv
`timescale 1ns/1ns
`default_nettype none
`include "adcc_defines.svh"
module test_adcc_conversion_control;
   logic clk = 1'b0;
   logic reset = 1'b1;
   logic [7:0] address = 8'h00;
   logic read = 1'b0;
   logic write = 1'b0;
   logic [31:0] writedata = 32'h0;
   logic [3:0] byteenable = 4'hf;
   logic [31:0] readdata;
   logic waitrequest;
   logic cmpAbove;
   adcc_pkg::adcc_analog_s analogCtrl;
   logic irq;
   logic [11:0] extLevel = 12'h000;
   logic [11:0] ampLevel = 12'h000;
   integer errors = 0;
   integer checksDone = 0;
   integer seed = 32'h77a7;
   integer cyc = 0;
   integer i, t;
   logic [31:0] rd;
   logic [3:0] ch;
   logic [11:0] v;
   logic [3:0] srcTab [8] = '{4'h0, 4'h4, 4'hc, 4'h1, 4'h5, 4'h7, 4'h8, 4'h2};
   initial forever #5 clk = ~clk;
   always @(posedge clk) cyc <= cyc + 1;
   adcc_conversion_control DUT (.clk(clk), .reset(reset), .address(address), .read(read), .write(write),
      .writedata(writedata), .byteenable(byteenable), .readdata(readdata), .waitrequest(waitrequest),
      .cmpAbove(cmpAbove), .analogCtrl(analogCtrl), .irq(irq));
   adcc_analog_model partner (.clk(clk), .analogCtrl(analogCtrl), .extLevel(extLevel), .ampLevel(ampLevel),
      .cmpAbove(cmpAbove));
   task automatic check(input string what, input logic [31:0] seen, input logic [31:0] exp);
      checksDone = checksDone + 1;
      if (seen !== exp) begin
         errors = errors + 1;
         $display("Error %s expected %h seen %h", what, exp, seen);
      end
   endtask : check
   task automatic end_of_test;
      if (errors == 0 && checksDone > 0) begin
         $display("Result: passed");
      end else begin
         $display("Result: failed");
      end
      $finish;
   endtask : end_of_test
   // Holds the request until waitrequest is seen low, then leaves one idle cycle
   task automatic bus(input logic wr, input logic [7:0] a, input logic [7:0] d);
      integer k;
      k = 0;
      address <= a;
      read <= !wr;
      write <= wr;
      writedata <= {24'h0, d};
      @(posedge clk);
      while (waitrequest !== 1'b0 && k < 20) begin
         @(posedge clk);
         k = k + 1;
      end
      check("waitrequest", waitrequest, 1'b0);
      rd = readdata;
      read <= 1'b0;
      write <= 1'b0;
      @(posedge clk);
   endtask : bus
   task automatic rc(input string w, input logic [7:0] a, input logic [31:0] exp);
      bus(1'b0, a, 8'h00);
      check(w, rd, exp);
   endtask : rc
   task automatic irqchk(input logic exp);
      @(posedge clk);
      check("irq", irq, exp);
   endtask : irqchk
   function automatic logic [3:0] src_exp(input logic [3:0] s);
      if (s == 4'h0 || s == 4'h4 || s[3:2] == 2'b11) src_exp = 4'h8;
      else if (s[3:2] == 2'b10) src_exp = 4'h4;
      else src_exp = {1'b0, s[2:0]};
   endfunction : src_exp
   function automatic logic [11:0] lvl_exp(input logic [3:0] s, input logic [3:0] c);
      case (src_exp(s))
         4'h8: lvl_exp = extLevel ^ {8'h00, c};
         4'h1: lvl_exp = 12'hfff;
         4'h2: lvl_exp = 12'h7ff;
         4'h3: lvl_exp = 12'h3ff;
         4'h5: lvl_exp = ampLevel;
         4'h6: lvl_exp = ampLevel >> 1;
         4'h7: lvl_exp = ampLevel >> 2;
         default: lvl_exp = 12'h000;
      endcase
   endfunction : lvl_exp
   task automatic conv(input logic [2:0] dv, input logic fmt, input logic [3:0] s, input logic ie);
      bus(1'b1, `ADCC_OFF_CTRL1, {s, 1'b0, dv});
      bus(1'b1, `ADCC_OFF_CTRL0, {3'b101, fmt, ch});
      rc("busy before fall", `ADCC_OFF_CTRL0, {8'h00, 3'b101, fmt, ch});
      bus(1'b1, `ADCC_OFF_CTRL0, {3'b001, fmt, ch});
      t = cyc;
      rc("busy after launch", `ADCC_OFF_CTRL0, {8'h00, 3'b011, fmt, ch});
      while (rd[6] !== 1'b0 && cyc - t < 5000) bus(1'b0, `ADCC_OFF_CTRL0, 8'h00);
      t = cyc - t;
      // Each poll is a three-cycle read, so completion shows 3 to 5 cycles late
      check("conversion time", t >= (16 << dv) + 3 && t <= (16 << dv) + 5, 1'b1);
      rc("request flag", `ADCC_OFF_IRQST, 32'h1);
      check("irq at done", irq, ie);
      // Below divide by 4 the synchronised comparator lags the trial code
      if (dv > 3'h1) begin
         v = lvl_exp(s, ch);
         rc("result high", `ADCC_OFF_RESH, fmt ? {28'h0, v[11:8]} : {24'h0, v[11:4]});
         rc("result low", `ADCC_OFF_RESL, fmt ? {24'h0, v[7:0]} : {24'h0, v[3:0], 4'h0});
      end
   endtask : conv
   initial begin
      #600000;
      check("watchdog", 1'b1, 1'b0);
      end_of_test();
   end
   initial begin
      repeat (8) @(posedge clk);
      reset <= 1'b0;
      bus(1'b1, 8'h20, 8'hff);
      for (i = 0; i < 9; i++) rc("reset value", i * 4, 32'h0);
      check("irq reset", irq, 1'b0);
      // A write without lane zero enabled must not land
      byteenable <= 4'he;
      bus(1'b1, `ADCC_OFF_GIE, 8'h01);
      byteenable <= 4'hf;
      rc("lane zero off", `ADCC_OFF_GIE, 32'h0);
      for (i = 0; i < 16; i++) begin
         ch = $random(seed);
         bus(1'b1, `ADCC_OFF_CTRL0, {4'h0, ch});
         bus(1'b1, `ADCC_OFF_CTRL1, i << 4);
         repeat (2) @(posedge clk);
         check("route", {analogCtrl.route.extConnect, analogCtrl.route.intSrc}, src_exp(i));
         if (src_exp(i) == 4'h8) check("channel", analogCtrl.route.extChan, ch);
      end
      for (i = 0; i < 4; i++) begin
         bus(1'b1, `ADCC_OFF_CTRL2, (i << 2) | 8'hf3);
         rc("reference field", `ADCC_OFF_CTRL2, i << 2);
         check("reference", analogCtrl.refSel, i[1] ? 2'h2 : i[1:0]);
      end
      for (i = 0; i < 8; i++) begin
         ch = $random(seed);
         extLevel <= (i == 2) ? (12'hfff ^ {8'h00, ch}) : $random(seed);
         ampLevel <= $random(seed);
         if (i == 4) bus(1'b1, `ADCC_OFF_IRQEN, 8'h01);
         if (i == 4) bus(1'b1, `ADCC_OFF_GIE, 8'h01);
         conv(i, i[0], srcTab[i], i >= 4);
         // Results at the fastest dividers are taken again at an in-range clock
         if (i < 2) conv(3'h6, i[0], srcTab[i], 1'b0);
         if (i == 5) begin
            bus(1'b1, `ADCC_OFF_IRQEN, 8'h00);
            irqchk(1'b0);
            bus(1'b1, `ADCC_OFF_IRQEN, 8'h01);
            irqchk(1'b1);
            bus(1'b1, `ADCC_OFF_GIE, 8'h00);
            irqchk(1'b0);
            bus(1'b1, `ADCC_OFF_GIE, 8'h01);
         end
         bus(1'b1, `ADCC_OFF_IRQST, 8'h01);
         irqchk(1'b0);
         rc("flag cleared", `ADCC_OFF_IRQST, 32'h0);
      end
      // Start pulse without power is refused
      bus(1'b1, `ADCC_OFF_CTRL0, 8'h80);
      bus(1'b1, `ADCC_OFF_CTRL0, 8'h00);
      rc("unpowered start", `ADCC_OFF_CTRL0, 32'h0);
      // Power removed mid conversion aborts with no flag
      bus(1'b1, `ADCC_OFF_CTRL1, 8'h03);
      bus(1'b1, `ADCC_OFF_CTRL0, 8'ha0);
      bus(1'b1, `ADCC_OFF_CTRL0, 8'h20);
      rc("busy running", `ADCC_OFF_CTRL0, 32'h60);
      bus(1'b1, `ADCC_OFF_CTRL0, 8'h00);
      repeat (200) @(posedge clk);
      rc("abort busy", `ADCC_OFF_CTRL0, 32'h0);
      rc("abort flag", `ADCC_OFF_IRQST, 32'h0);
      end_of_test();
   end
endmodule : test_adcc_conversion_control
`default_nettype wire

// File: verilog/adcc_conversion_control.sv
// Behaviour
// RQ1: a conversion launches when software pulses the start bit high then low.
// RQ2: busy flag is set on launch and stays set throughout the conversion.
// RQ3: at completion busy clears and the interrupt request flag sets together.
// RQ4: interrupt output only when request pending and both enables are set.
// RQ5: software sets global and converter interrupt enables before starting.
// RQ6: with interrupt disabled, software polls busy until it reads zero.
// RQ7: converter clock is system clock divided by 1..128 by 3-bit select.
// RQ8: software picks a divider keeping the converter clock period in range.
// RQ9: power enable must be high to convert; software waits for settling.
// RQ10: conversion takes 4 sampling plus 12 converting clocks, 16 in total.
// RQ11: 12-bit result, reference input gives full scale fff.
// RQ12: completed result held in high and low result bytes after busy falls.
// RQ13: source codes 0000, 0100, 11xx route the selected external channel.
// RQ14: other source codes pick an internal signal and disconnect the channel.
// RQ15: format bit chooses how the result spreads over the two bytes.
// RQ16: format clear left-justifies, set right-justifies, unused bits zero.
// RQ17: reference select 00 supply, 01 reference pin, 1x amplifier output.
// RQ18: internal codes map to supply, amplifier fractions and analog ground.
`timescale 1ns/1ns
`default_nettype none
`include "adcc_defines.svh"

module adcc_conversion_control (
   // Clock and reset
   input wire logic clk,
   input wire logic reset,
   // Avalon-MM slave
   input wire logic [7:0] address,
   input wire logic read,
   input wire logic write,
   input wire logic [31:0] writedata,
   input wire logic [3:0] byteenable,
   output logic [31:0] readdata,
   output logic waitrequest,
   // Analog side
   input wire logic cmpAbove,
   output adcc_pkg::adcc_analog_s analogCtrl,
   // Interrupt
   output logic irq
);

   function automatic logic [6:0] divLimit(input logic [2:0] sel);
      divLimit = 7'((8'h01 << sel) - 8'h01);
   endfunction : divLimit

   function automatic adcc_pkg::adcc_route_s decodeRoute(input logic [3:0] src, input logic [3:0] chan);
      adcc_pkg::adcc_route_s r;
      r.extChan = chan;
      r.extConnect = 1'b0;
      r.intSrc = adcc_pkg::ADCC_INT_NONE;
      if (src == 4'h0 || src == 4'h4 || src[3:2] == 2'h3) begin
         r.extConnect = 1'b1; // RQ13
      end else if (src[3:2] == 2'h2) begin
         r.intSrc = adcc_pkg::ADCC_INT_GROUND; // RQ18
      end else begin
         r.intSrc = adcc_pkg::adcc_intsrc_e'(src[2:0]); // RQ14 RQ18
      end
      decodeRoute = r;
   endfunction : decodeRoute

   // Software visible state
   logic [3:0] chanQ;
   logic fmtQ;
   logic powerQ;
   logic startQ;
   logic startPrevQ;
   logic [2:0] divSelQ;
   logic [3:0] srcQ;
   logic [1:0] refQ;
   logic irqStatQ;
   logic irqEnQ;
   logic gieQ;
   logic busyQ;
   logic [11:0] resultQ;

   // Bus handshake
   logic ackQ;
   logic busReq;
   logic wrTake;
   logic [31:0] rdData_d;
   logic [7:0] wb;

   // Conversion engine
   adcc_pkg::adcc_state_e stateQ;
   logic [6:0] divCntQ;
   logic [3:0] phaseCntQ;
   logic [3:0] bitIdxQ;
   logic [11:0] sarQ;
   logic cmpMetaQ;
   logic cmpSyncQ;
   logic tick;
   logic launch;
   logic done;
   logic [11:0] trial;
   logic [7:0] resHigh;
   logic [7:0] resLow;

   assign busReq = read | write;
   // One wait state on every access so read data can come from a flop
   assign waitrequest = busReq & ~ackQ;
   assign wrTake = write & ackQ & byteenable[0];
   assign wb = writedata[7:0];

   always_ff @(posedge clk) begin
      if (reset) begin
         ackQ <= 1'b0;
      end else begin
         ackQ <= busReq & ~ackQ;
      end
   end

   // Result arrangement over the two bytes
   always_comb begin
      if (fmtQ) begin
         resHigh = {4'h0, resultQ[11:8]}; // RQ15 RQ16
         resLow = resultQ[7:0];
      end else begin
         resHigh = resultQ[11:4]; // RQ16
         resLow = {resultQ[3:0], 4'h0};
      end
   end

   always_comb begin
      rdData_d = 32'h0000_0000;
      if (address == `ADCC_OFF_CTRL0) begin
         rdData_d[7:0] = {startQ, busyQ, powerQ, fmtQ, chanQ}; // RQ6
      end else if (address == `ADCC_OFF_CTRL1) begin
         rdData_d[7:0] = {srcQ, 1'b0, divSelQ};
      end else if (address == `ADCC_OFF_CTRL2) begin
         rdData_d[7:0] = {4'h0, refQ, 2'h0};
      end else if (address == `ADCC_OFF_RESH) begin
         rdData_d[7:0] = resHigh; // RQ12
      end else if (address == `ADCC_OFF_RESL) begin
         rdData_d[7:0] = resLow; // RQ12
      end else if (address == `ADCC_OFF_IRQST) begin
         rdData_d[0] = irqStatQ;
      end else if (address == `ADCC_OFF_IRQEN) begin
         rdData_d[0] = irqEnQ;
      end else if (address == `ADCC_OFF_GIE) begin
         rdData_d[0] = gieQ;
      end
   end

   always_ff @(posedge clk) begin
      if (reset) begin
         readdata <= 32'h0000_0000;
      end else if (read & ~ackQ) begin
         readdata <= rdData_d;
      end
   end

   // Control registers
   always_ff @(posedge clk) begin
      if (reset) begin
         chanQ <= `ADCC_RST_CHAN;
         fmtQ <= 1'b0;
         powerQ <= 1'b0;
         startQ <= 1'b0;
         divSelQ <= `ADCC_RST_DIV;
         srcQ <= `ADCC_RST_SRC;
         refQ <= `ADCC_RST_REF;
         irqEnQ <= 1'b0;
         gieQ <= 1'b0;
      end else if (wrTake) begin
         if (address == `ADCC_OFF_CTRL0) begin
            chanQ <= wb[`ADCC_C0_CHAN_LSB +: 4];
            fmtQ <= wb[`ADCC_C0_FMT];
            powerQ <= wb[`ADCC_C0_PWR];
            startQ <= wb[`ADCC_C0_START];
         end else if (address == `ADCC_OFF_CTRL1) begin
            divSelQ <= wb[`ADCC_C1_DIV_LSB +: 3];
            srcQ <= wb[`ADCC_C1_SRC_LSB +: 4];
         end else if (address == `ADCC_OFF_CTRL2) begin
            refQ <= wb[`ADCC_C2_REF_LSB +: 2];
         end else if (address == `ADCC_OFF_IRQEN) begin
            irqEnQ <= wb[0];
         end else if (address == `ADCC_OFF_GIE) begin
            gieQ <= wb[0];
         end
      end
   end

   // Launch on the falling half of a high-low start pulse
   always_ff @(posedge clk) begin
      if (reset) begin
         startPrevQ <= 1'b0;
      end else begin
         startPrevQ <= startQ;
      end
   end
   assign launch = startPrevQ & ~startQ & powerQ; // RQ1 RQ9

   // Converter clock divider, restarted on launch so the first period is whole
   assign tick = (divCntQ == divLimit(divSelQ)); // RQ7
   always_ff @(posedge clk) begin
      if (reset) begin
         divCntQ <= 7'h00;
      end else if (launch || tick || stateQ == adcc_pkg::ADCC_IDLE) begin
         divCntQ <= 7'h00;
      end else begin
         divCntQ <= divCntQ + 7'h01;
      end
   end

   // Comparator arrives from the analog domain
   always_ff @(posedge clk) begin
      if (reset) begin
         cmpMetaQ <= 1'b0;
         cmpSyncQ <= 1'b0;
      end else begin
         cmpMetaQ <= cmpAbove;
         cmpSyncQ <= cmpMetaQ;
      end
   end

   assign trial = sarQ | (12'h001 << bitIdxQ);
   assign done = (stateQ == adcc_pkg::ADCC_CONVERT) && tick && (bitIdxQ == 4'h0) && powerQ;

   // Sample then successive approximation, one bit per converter clock
   always_ff @(posedge clk) begin
      if (reset) begin
         stateQ <= adcc_pkg::ADCC_IDLE;
         phaseCntQ <= 4'h0;
         bitIdxQ <= 4'h0;
         sarQ <= 12'h000;
      end else if (launch) begin
         // A new pulse during a conversion restarts it from sampling
         stateQ <= adcc_pkg::ADCC_SAMPLE;
         phaseCntQ <= 4'h0;
         bitIdxQ <= `ADCC_RES_MSB;
         sarQ <= 12'h000;
      end else if (!powerQ) begin
         // Power removed aborts without a completion event
         stateQ <= adcc_pkg::ADCC_IDLE;
      end else begin
         case (stateQ)
            adcc_pkg::ADCC_SAMPLE: begin
               if (tick) begin
                  if (phaseCntQ == `ADCC_SAMPLE_CLKS - 4'h1) begin
                     stateQ <= adcc_pkg::ADCC_CONVERT; // RQ10
                  end
                  phaseCntQ <= phaseCntQ + 4'h1;
               end
            end
            adcc_pkg::ADCC_CONVERT: begin
               if (tick) begin
                  if (cmpSyncQ) begin
                     sarQ <= trial; // RQ11
                  end
                  phaseCntQ <= phaseCntQ + 4'h1;
                  bitIdxQ <= bitIdxQ - 4'h1;
                  if (bitIdxQ == 4'h0) begin
                     stateQ <= adcc_pkg::ADCC_IDLE; // RQ10
                  end
               end
            end
            default: begin
               stateQ <= adcc_pkg::ADCC_IDLE;
            end
         endcase
      end
   end

   always_ff @(posedge clk) begin
      if (reset) begin
         resultQ <= `ADCC_RST_RESULT;
      end else if (done) begin
         resultQ <= cmpSyncQ ? trial : sarQ; // RQ11 RQ12
      end
   end

   always_ff @(posedge clk) begin
      if (reset) begin
         busyQ <= 1'b0;
      end else if (launch) begin
         busyQ <= 1'b1; // RQ2
      end else if (done || !powerQ) begin
         busyQ <= 1'b0; // RQ3
      end
   end

   // Request flag: write one clears, a completion in the same cycle wins
   always_ff @(posedge clk) begin
      if (reset) begin
         irqStatQ <= 1'b0;
      end else begin
         irqStatQ <= (irqStatQ & ~(wrTake && address == `ADCC_OFF_IRQST && wb[0])) | done; // RQ3
      end
   end

   always_ff @(posedge clk) begin
      if (reset) begin
         irq <= 1'b0;
      end else begin
         irq <= irqStatQ & irqEnQ & gieQ; // RQ4 RQ5
      end
   end

   // Analog controls come from flops so the analog side sees clean levels
   always_ff @(posedge clk) begin
      if (reset) begin
         analogCtrl <= '0;
      end else begin
         analogCtrl.powerOn <= powerQ; // RQ9
         analogCtrl.sampling <= (stateQ == adcc_pkg::ADCC_SAMPLE);
         analogCtrl.converting <= (stateQ == adcc_pkg::ADCC_CONVERT);
         analogCtrl.trialCode <= trial;
         analogCtrl.route <= decodeRoute(srcQ, chanQ); // RQ13 RQ14
         analogCtrl.refSel <= refQ[1] ? adcc_pkg::ADCC_REF_AMP : adcc_pkg::adcc_ref_e'(refQ); // RQ17
      end
   end

endmodule : adcc_conversion_control
`default_nettype wire

// File: verilog/adcc_defines.svh
`ifndef ADCC_DEFINES_SVH
`define ADCC_DEFINES_SVH

// Register byte offsets
`define ADCC_OFF_CTRL0 8'h00
`define ADCC_OFF_CTRL1 8'h04
`define ADCC_OFF_CTRL2 8'h08
`define ADCC_OFF_RESH 8'h0c
`define ADCC_OFF_RESL 8'h10
`define ADCC_OFF_IRQST 8'h14
`define ADCC_OFF_IRQEN 8'h18
`define ADCC_OFF_GIE 8'h1c

// converter_control_0 fields
`define ADCC_C0_CHAN_LSB 0
`define ADCC_C0_FMT 4
`define ADCC_C0_PWR 5
`define ADCC_C0_BUSY 6
`define ADCC_C0_START 7
// converter_control_1 fields
`define ADCC_C1_DIV_LSB 0
`define ADCC_C1_SRC_LSB 4
// converter_control_2 fields
`define ADCC_C2_REF_LSB 2

// Reset values
`define ADCC_RST_CHAN 4'h0
`define ADCC_RST_DIV 3'h0
`define ADCC_RST_SRC 4'h0
`define ADCC_RST_REF 2'h0
`define ADCC_RST_RESULT 12'h000

// Conversion timing in converter clocks
`define ADCC_SAMPLE_CLKS 4'h4
`define ADCC_CONV_CLKS 4'hc
`define ADCC_RES_MSB 4'hb

`endif

// File: verilog/adcc_pkg.sv
`default_nettype none
package adcc_pkg;

   // Gray coded along idle -> sample -> convert
   typedef enum logic [1:0] {
      ADCC_IDLE = 2'h0,
      ADCC_SAMPLE = 2'h1,
      ADCC_CONVERT = 2'h3
   } adcc_state_e;

   typedef enum logic [2:0] {
      ADCC_INT_NONE = 3'h0,
      ADCC_INT_SUPPLY = 3'h1,
      ADCC_INT_SUPPLY_DIV2 = 3'h2,
      ADCC_INT_SUPPLY_DIV4 = 3'h3,
      ADCC_INT_GROUND = 3'h4,
      ADCC_INT_AMP = 3'h5,
      ADCC_INT_AMP_DIV2 = 3'h6,
      ADCC_INT_AMP_DIV4 = 3'h7
   } adcc_intsrc_e;

   typedef enum logic [1:0] {
      ADCC_REF_SUPPLY = 2'h0,
      ADCC_REF_PIN = 2'h1,
      ADCC_REF_AMP = 2'h2
   } adcc_ref_e;

   typedef struct packed {
      logic extConnect;
      logic [3:0] extChan;
      adcc_intsrc_e intSrc;
   } adcc_route_s;

   typedef struct packed {
      logic powerOn;
      logic sampling;
      logic converting;
      logic [11:0] trialCode;
      adcc_route_s route;
      adcc_ref_e refSel;
   } adcc_analog_s;

endpackage : adcc_pkg
`default_nettype wire
